//--- common/stc_pkg.sv
package stc_pkg;
    localparam int          DATA_W        = 8;
    localparam int          COUNT_W       = 16;
    localparam logic [3:0]  ADDR_CTRL_A   = 4'h0;
    localparam logic [3:0]  ADDR_CTRL_B   = 4'h1;
    localparam logic [3:0]  ADDR_CNT_LO   = 4'h4;
    localparam logic [3:0]  ADDR_CNT_HI   = 4'h5;
    localparam logic [3:0]  ADDR_CMPA_LO  = 4'h8;
    localparam logic [3:0]  ADDR_CMPA_HI  = 4'h9;
    localparam logic [3:0]  ADDR_CMPB_LO  = 4'ha;
    localparam logic [3:0]  ADDR_CMPB_HI  = 4'hb;
    localparam logic [3:0]  ADDR_CAP_LO   = 4'hc;
    localparam logic [3:0]  ADDR_CAP_HI   = 4'hd;
    localparam logic [3:0]  ADDR_FLAGS    = 4'he;
    localparam int          CS_POS        = 0;
    localparam int          WGM_HI_POS    = 3;
    localparam int          WGM_LO_POS    = 0;
    localparam int          FLAG_OVF_POS  = 0;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] MAX_VALUE     = 16'hffff;
    localparam logic [2:0]  CS_STOPPED    = 3'h0;
    localparam logic [2:0]  CS_EXT_FALL   = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE   = 3'h7;
endpackage

//--- common/stc_tick_if.sv
`timescale 1ns/100ps
interface stc_tick_if;
    logic [2:0] clock_select_field;
    logic       timer_tick;
    modport src (input clock_select_field, output timer_tick);
    modport dst (output clock_select_field, input timer_tick);
endinterface

//--- testbench/stc_counter_core_asserts.sv
`timescale 1ns/100ps
module stc_counter_core_asserts #(
    parameter int COUNT_W = 16
) (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic [3:0]         addr,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire logic [7:0]         wdata,
    input wire logic [7:0]         rdata,
    input wire logic               count_down,
    input wire logic               clear_count,
    input wire logic [COUNT_W-1:0] top_value,
    input wire logic               ovf_at_top,
    input wire logic [COUNT_W-1:0] count_value,
    input wire logic               top_reached,
    input wire logic               zero_reached,
    input wire logic               timer_tick,
    input wire logic               overflow_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire logic       lo_wr  = wr_en && addr == stc_pkg::ADDR_CNT_LO;
    wire logic [7:0] cnt_lo = count_value[7:0];
    // Bench spaces its bus cycles one idle edge apart; a read of the
    // low byte in the gap would reload the holder, so it is excluded
    sequence s_wide_wr;
        wr_en && addr == stc_pkg::ADDR_CNT_HI
        ##1 !wr_en && !rd_en
        ##1 lo_wr;
    endsequence
    a_hold_no_tick: assert property (!timer_tick && !lo_wr
        |=> $stable(count_value))
        else $error("count moved without tick");
    a_step_up: assert property (timer_tick && !lo_wr
        && !clear_count && !count_down
        |=> count_value == $past(count_value) + 1'b1)
        else $error("bad up step");
    a_step_down: assert property (timer_tick && !lo_wr
        && !clear_count && count_down
        |=> count_value == $past(count_value) - 1'b1)
        else $error("bad down step");
    a_clear_zero: assert property (timer_tick && !lo_wr
        && clear_count
        |=> count_value == '0)
        else $error("clear failed");
    a_wide_write: assert property (s_wide_wr
        |=> count_value == {$past(wdata, 3), $past(wdata)})
        else $error("wide write wrong");
    a_zero_flag: assert property (zero_reached
        == (count_value == '0))
        else $error("zero flag wrong");
    a_top_flag: assert property (top_reached
        == (count_value == top_value))
        else $error("top flag wrong");
    a_ovf_set: assert property (timer_tick && !lo_wr
        && (ovf_at_top ? count_value == top_value : count_value == '0)
        |=> overflow_flag)
        else $error("overflow not set");
    a_low_read: assert property (rd_en
        && addr == stc_pkg::ADDR_CNT_LO
        |=> rdata == $past(cnt_lo))
        else $error("low read wrong");
    a_write_wins: assert property (lo_wr
        |=> count_value[7:0] == $past(wdata))
        else $error("counter write lost");
endmodule

bind stc_counter_core stc_counter_core_asserts #(.COUNT_W(COUNT_W)) i_chk (
    .clock, .rst, .addr, .wr_en, .rd_en, .wdata, .rdata, .count_down,
    .clear_count, .top_value, .ovf_at_top, .count_value, .top_reached,
    .zero_reached, .timer_tick, .overflow_flag);

//--- testbench/stc_counter_core_tb.sv
`timescale 1ns/100ps
module stc_counter_core_tb;
    logic        clock = 0, rst = 1, wr_en = 0, rd_en = 0, ext_pin = 0;
    logic        count_down = 0, clear_count = 0, ovf_at_top = 1;
    logic        capture_strobe = 0, overflow_clear = 0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, prescale_taps = 8'h00, rdata, d;
    logic [15:0] top_value = 16'hffff, capture_value = 16'h0000;
    logic [15:0] count_value, compare_a, compare_b;
    logic [3:0]  waveform_mode_field;
    logic        top_reached, zero_reached, timer_tick, overflow_flag;
    int          num_errors = 0, n_compared = 0, cycles = 0;

    always #5 clock = ~clock;

    stc_counter_core i_stc_counter_core (.clock, .rst, .addr, .wr_en,
        .rd_en, .wdata, .rdata, .prescale_taps, .ext_pin, .count_down,
        .clear_count, .top_value, .ovf_at_top, .capture_value,
        .capture_strobe, .overflow_clear, .count_value, .compare_a,
        .compare_b, .waveform_mode_field, .top_reached, .zero_reached,
        .timer_tick, .overflow_flag);

    task results;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Bytes and flags are widened so one compare serves every value
    task chk(input string name, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        #1;
    endtask

    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Select code 1 takes its tick from tap 1
    task tick(input int n, input logic dn, clr);
        repeat (n) begin
            @(posedge clock);
            prescale_taps <= 8'h02;
            count_down <= dn;
            clear_count <= clr;
            @(posedge clock);
            prescale_taps <= 8'h00;
        end
        #1;
    endtask

    task t_reset;
        #1;
        chk("count", 16'h0000, count_value);
        chk("zero", 16'h0001, {15'h0, zero_reached});
        chk("ovf", 16'h0000, {15'h0, overflow_flag});
        chk("rdata", 16'h0000, {8'h00, rdata});
    endtask

    // The compare B high read falls between the two halves of the counter read
    task t_bytes;
        wr(4'h5, 8'h01);
        wr(4'h4, 8'hff);
        chk("count", 16'h01ff, count_value);
        wr(4'h5, 8'h12);
        wr(4'h4, 8'h34);
        wr(4'h8, 8'h56);
        chk("count", 16'h1234, count_value);
        chk("cmp_a", 16'h1256, compare_a);
        wr(4'h5, 8'h77);
        wr(4'ha, 8'h00);
        chk("cmp_b", 16'h7700, compare_b);
        rd(4'h4, d);
        chk("cnt_lo", 16'h0034, {8'h00, d});
        rd(4'hb, d);
        chk("cmp_b_hi", 16'h0077, {8'h00, d});
        rd(4'h5, d);
        chk("cnt_hi", 16'h0012, {8'h00, d});
        rd(4'h7, d);
        chk("unmapped", 16'h0000, {8'h00, d});
    endtask

    task t_count;
        wr(4'h5, 8'hff);
        wr(4'h4, 8'hfe);
        wr(4'h0, 8'h03);
        wr(4'h1, 8'h19);
        chk("wgm", 16'h000f, {12'h0, waveform_mode_field});
        tick(2, 1'b0, 1'b0);
        chk("count", 16'h0000, count_value);
        chk("ovf", 16'h0001, {15'h0, overflow_flag});
        wr(4'he, 8'h01);
        chk("ovf", 16'h0000, {15'h0, overflow_flag});
        tick(1, 1'b1, 1'b0);
        chk("top", 16'h0001, {15'h0, top_reached});
        tick(1, 1'b0, 1'b1);
        chk("count", 16'h0000, count_value);
        @(posedge clock);
        overflow_clear <= 1'b1;
        @(posedge clock);
        overflow_clear <= 1'b0;
        #1;
        chk("ovf", 16'h0000, {15'h0, overflow_flag});
        // Zero_reached point, with a clear pulse landing on the same edge
        @(posedge clock);
        ovf_at_top <= 1'b0;
        overflow_clear <= 1'b1;
        prescale_taps <= 8'h02;
        @(posedge clock);
        ovf_at_top <= 1'b1;
        overflow_clear <= 1'b0;
        prescale_taps <= 8'h00;
        #1;
        chk("ovf_set_wins", 16'h0001, {15'h0, overflow_flag});
    endtask

    task t_prio;
        wr(4'h1, 8'h18);
        @(posedge clock);
        prescale_taps <= 8'hff;
        clear_count <= 1'b1;
        #1;
        chk("tick", 16'h0000, {15'h0, timer_tick});
        // Tap stays high so each write after the select change also carries a clear tick
        wr(4'h1, 8'h19);
        wr(4'h5, 8'hab);
        wr(4'h4, 8'hcd);
        chk("count", 16'habcd, count_value);
        @(posedge clock);
        prescale_taps <= 8'h00;
    endtask

    task t_capture;
        @(posedge clock);
        capture_value <= 16'hbeef;
        capture_strobe <= 1'b1;
        @(posedge clock);
        capture_strobe <= 1'b0;
        rd(4'hc, d);
        chk("cap_lo", 16'h00ef, {8'h00, d});
        rd(4'hd, d);
        chk("cap_hi", 16'h00be, {8'h00, d});
    endtask

    // Pin edges reach the counter three edges after the pin moves
    task t_pin;
        @(posedge clock);
        clear_count <= 1'b0;
        count_down <= 1'b0;
        wr(4'h5, 8'h00);
        wr(4'h4, 8'h10);
        wr(4'h1, 8'h07);
        @(posedge clock);
        ext_pin <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        chk("pin_rise", 16'h0011, count_value);
        wr(4'h1, 8'h06);
        @(posedge clock);
        ext_pin <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk("pin_fall", 16'h0012, count_value);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            results;
        end
    end

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_bytes;
        t_count;
        t_prio;
        t_capture;
        t_pin;
        results;
    end
endmodule

//--- verilog/stc_clock_select.sv
`timescale 1ns/100ps
module stc_clock_select (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic [7:0] prescale_taps,
    input  wire logic ext_pin,
    stc_tick_if.src   tick
);
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic ext_rise;
    logic ext_fall;

    // Pin passes two flops before the edge detector reads it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    assign ext_rise = ext_sync & ~ext_prev;
    assign ext_fall = ~ext_sync & ext_prev;

    // Zero stops the timer; prescaled taps are strobes from outside
    always_comb begin
        case (tick.clock_select_field)
            stc_pkg::CS_STOPPED:  tick.timer_tick = 1'b0;
            stc_pkg::CS_EXT_FALL: tick.timer_tick = ext_fall;
            stc_pkg::CS_EXT_RISE: tick.timer_tick = ext_rise;
            default: tick.timer_tick =
                prescale_taps[tick.clock_select_field];
        endcase
    end
endmodule

//--- verilog/stc_counter_core.sv
`timescale 1ns/100ps
module stc_counter_core #(
    parameter int COUNT_W = stc_pkg::COUNT_W
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [3:0]          addr,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    input  wire logic [7:0]          wdata,
    output logic      [7:0]          rdata,
    input  wire logic [7:0]          prescale_taps,
    input  wire logic                ext_pin,
    input  wire logic                count_down,
    input  wire logic                clear_count,
    input  wire logic [COUNT_W-1:0]  top_value,
    input  wire logic                ovf_at_top,
    input  wire logic [COUNT_W-1:0]  capture_value,
    input  wire logic                capture_strobe,
    input  wire logic                overflow_clear,
    output logic [COUNT_W-1:0]       count_value,
    output logic [COUNT_W-1:0]       compare_a,
    output logic [COUNT_W-1:0]       compare_b,
    output logic [3:0]               waveform_mode_field,
    output logic                     top_reached,
    output logic                     zero_reached,
    output logic                     timer_tick,
    output logic                     overflow_flag
);
    logic [7:0]         timer_control_first;
    logic [7:0]         timer_control_second;
    logic [7:0]         holding;
    logic [COUNT_W-1:0] capture_value_reg;
    logic [COUNT_W-1:0] next_count;
    logic               next_ovf;
    logic               ovf_event;
    logic               wr_cnt_lo;
    logic               wr_hi_any;
    logic               rd_cnt_lo;
    logic               rd_cap_lo;
    logic               wr_cmpa_lo;
    logic               wr_cmpb_lo;
    logic               wr_cap_lo;
    logic               wr_flags;
    logic [7:0]         next_rdata;

    stc_tick_if tick_bus ();

    stc_clock_select u_clock_select (
        .clock         (clock),
        .rst           (rst),
        .prescale_taps (prescale_taps),
        .ext_pin       (ext_pin),
        .tick          (tick_bus.src)
    );

    assign tick_bus.clock_select_field =
        timer_control_second[stc_pkg::CS_POS +: 3];
    assign timer_tick = tick_bus.timer_tick;
    assign waveform_mode_field = {
        timer_control_second[stc_pkg::WGM_HI_POS +: 2],
        timer_control_first[stc_pkg::WGM_LO_POS +: 2]};

    assign wr_cnt_lo  = wr_en && addr == stc_pkg::ADDR_CNT_LO;
    assign wr_cmpa_lo = wr_en && addr == stc_pkg::ADDR_CMPA_LO;
    assign wr_cmpb_lo = wr_en && addr == stc_pkg::ADDR_CMPB_LO;
    assign wr_cap_lo  = wr_en && addr == stc_pkg::ADDR_CAP_LO;
    assign wr_flags   = wr_en && addr == stc_pkg::ADDR_FLAGS;
    // Every wide high byte lands in the one shared holder
    assign wr_hi_any  = wr_en && (addr == stc_pkg::ADDR_CNT_HI  ||
                                  addr == stc_pkg::ADDR_CMPA_HI ||
                                  addr == stc_pkg::ADDR_CMPB_HI ||
                                  addr == stc_pkg::ADDR_CAP_HI);
    assign rd_cnt_lo  = rd_en && addr == stc_pkg::ADDR_CNT_LO;
    assign rd_cap_lo  = rd_en && addr == stc_pkg::ADDR_CAP_LO;

    assign top_reached  = count_value == top_value;
    assign zero_reached = count_value == stc_pkg::COUNT_RESET;

    // Processor write first, then clear, then a step of one
    always_comb begin
        next_count = count_value;
        if (wr_cnt_lo) begin
            next_count = {holding, wdata};
        end else if (timer_tick) begin
            if (clear_count) begin
                next_count = stc_pkg::COUNT_RESET;
            end else if (count_down) begin
                next_count = count_value - COUNT_W'(1);
            end else begin
                next_count = count_value + COUNT_W'(1);
            end
        end
    end

    // Mode logic outside picks top or zero as the overflow point
    assign ovf_event = timer_tick && !wr_cnt_lo &&
        (ovf_at_top ? top_reached : zero_reached);
    // Set wins over a clear in the same cycle
    assign next_ovf = ovf_event ||
        (overflow_flag && !overflow_clear &&
         !(wr_flags && wdata[stc_pkg::FLAG_OVF_POS]));

    // Compare reads return live bytes and leave the holder alone
    always_comb begin
        case (addr)
            stc_pkg::ADDR_CTRL_A:  next_rdata = timer_control_first;
            stc_pkg::ADDR_CTRL_B:  next_rdata = timer_control_second;
            stc_pkg::ADDR_CNT_LO:  next_rdata = count_value[7:0];
            stc_pkg::ADDR_CNT_HI:  next_rdata = holding;
            stc_pkg::ADDR_CMPA_LO: next_rdata = compare_a[7:0];
            stc_pkg::ADDR_CMPA_HI: next_rdata = compare_a[15:8];
            stc_pkg::ADDR_CMPB_LO: next_rdata = compare_b[7:0];
            stc_pkg::ADDR_CMPB_HI: next_rdata = compare_b[15:8];
            stc_pkg::ADDR_CAP_LO:  next_rdata = capture_value_reg[7:0];
            stc_pkg::ADDR_CAP_HI:  next_rdata = holding;
            stc_pkg::ADDR_FLAGS:   next_rdata = {7'h00, overflow_flag};
            default:               next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_value <= stc_pkg::COUNT_RESET;
            overflow_flag <= 1'b0;
            rdata <= 8'h00;
        end else begin
            count_value <= next_count;
            overflow_flag <= next_ovf;
            rdata <= rd_en ? next_rdata : rdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_control_first  <= stc_pkg::CTRL_RESET;
            timer_control_second <= stc_pkg::CTRL_RESET;
        end else if (wr_en && addr == stc_pkg::ADDR_CTRL_A) begin
            timer_control_first  <= wdata;
        end else if (wr_en && addr == stc_pkg::ADDR_CTRL_B) begin
            timer_control_second <= wdata;
        end
    end

    // Low writes leave the holder intact for reuse
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            holding <= 8'h00;
        end else if (wr_hi_any) begin
            holding <= wdata;
        end else if (rd_cnt_lo) begin
            holding <= count_value[15:8];
        end else if (rd_cap_lo) begin
            holding <= capture_value_reg[15:8];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compare_a <= stc_pkg::COUNT_RESET;
            compare_b <= stc_pkg::COUNT_RESET;
        end else if (wr_cmpa_lo) begin
            compare_a <= {holding, wdata};
        end else if (wr_cmpb_lo) begin
            compare_b <= {holding, wdata};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capture_value_reg <= stc_pkg::COUNT_RESET;
        end else if (wr_cap_lo) begin
            capture_value_reg <= {holding, wdata};
        end else if (capture_strobe) begin
            capture_value_reg <= capture_value;
        end
    end
endmodule
